/* File: chg_pkg.sv */
// Shared constants for the charger limit and fault logic
package chg_pkg;
	// Register map
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_INPUT_LIMIT = 8'h01;
	localparam logic [7:0] ADDR_FLOAT_VOLT = 8'h02;
	localparam logic [7:0] ADDR_CHARGE_CUR = 8'h04;
	localparam logic [7:0] ADDR_FLOOR = 8'h05;
	localparam logic [7:0] ADDR_SAFETY = 8'h06;
	// Field positions
	localparam int CAP_LSB = 6;
	localparam int FLOAT_LSB = 2;
	localparam int CUR_LSB = 4;
	localparam int LOOP_BIT = 3;
	localparam int ICEIL_LSB = 4;
	localparam int VCEIL_LSB = 0;
	localparam int STAT_LSB = 4;
	localparam int FAULT_LSB = 0;
	// Reset values
	localparam logic [7:0] INPUT_LIMIT_RST = 8'h00;
	localparam logic [7:0] FLOAT_VOLT_RST = 8'h00;
	localparam logic [7:0] CHARGE_CUR_RST = 8'h00;
	localparam logic [7:0] FLOOR_RST = 8'h00;
	localparam logic [7:0] SAFETY_RST = 8'h00;
	// Fault and status codes
	localparam logic [2:0] FLT_NONE = 3'h0;
	localparam logic [2:0] FLT_OVP = 3'h1;
	localparam logic [2:0] FLT_UVLO = 3'h3;
	localparam logic [2:0] FLT_THERM = 3'h5;
	localparam logic [1:0] STS_READY = 2'h0;
	localparam logic [1:0] STS_CHARGING = 2'h1;
	localparam logic [1:0] STS_FAULT = 2'h3;
	// Decode figures, mA and mV
	localparam logic [11:0] CAP_MA_0 = 12'h064;
	localparam logic [11:0] CAP_MA_1 = 12'h1F4;
	localparam logic [11:0] CAP_MA_2 = 12'h320;
	localparam logic [11:0] CAP_NO_LIMIT = 12'hFFF;
	localparam logic [12:0] FLOOR_BASE_MV = 13'h1075;
	localparam logic [12:0] FLOOR_STEP_MV = 13'h0050;
	localparam logic [11:0] CUR_BASE_MA = 12'h226;
	localparam logic [11:0] CUR_STEP_MA = 12'h064;
	localparam logic [11:0] CUR_MAX_MA = 12'h60E;
	localparam logic [3:0] ICEIL_LAST = 4'h9;
	localparam logic [5:0] VCEIL_BASE_CODE = 6'h23;
	localparam logic [3:0] VCEIL_LAST = 4'hB;
	localparam logic [11:0] FOLDBACK_MA = 12'h226;
	// Timing
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned CYC_PER_US = 1000000 / CLK_PERIOD_PS;
	localparam int unsigned CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
	localparam int unsigned PULSE_TIME_US = 128;
	localparam int unsigned PULSE_CYC = PULSE_TIME_US * CYC_PER_US;
	localparam int unsigned RETRY_TIME_MS = 2000;
	localparam int unsigned RETRY_CYC = RETRY_TIME_MS * CYC_PER_MS;
	// Charge control states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_CHARGE = 6'b000010,
		ST_THERM = 6'b000100,
		ST_UVWAIT = 6'b001000,
		ST_OVP = 6'b010000,
		ST_SLEEP = 6'b100000
	} chg_state_e;
endpackage

/* File: chg_stat_pulse.sv */
// Event pin pulse stretcher
`timescale 1ns/1ps
module chg_stat_pulse import chg_pkg::*; #(
	parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic trigger,
	output logic pulseActive
);
	initial begin
		if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) $error("PULSE_CYCLES out of range");
	end

	logic [15:0] count_ff;
	logic [15:0] nxt_count;

	// A new fault during a pulse restarts it, so the host always sees a full width
	always_comb begin
		nxt_count = count_ff;
		if (trigger) begin
			nxt_count = 16'(PULSE_CYCLES);
		end else if (count_ff != 16'h0000) begin
			nxt_count = count_ff - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count_ff <= 16'h0000;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign pulseActive = (count_ff != 16'h0000);

	a_pulse_width: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(pulseActive) |-> count_ff == 16'(PULSE_CYCLES))
		else $error("event pulse started with wrong width");
	// Width is loaded on the start and then counted down one per cycle until the pin opens
	a_pulse_count: assert property (@(posedge clk_sys) disable iff (!rstn)
		pulseActive && !trigger |=> count_ff == $past(count_ff) - 16'h0001)
		else $error("event pulse did not count down");
endmodule // chg_stat_pulse

/* File: chg_limit_fault.sv */
// Charger input limit, safety clamp and fault control
`timescale 1ns/1ps
// Overview of operation
// - Two-bit input cap selects 100, 500, 800 mA or no limit.
// - Ramp charge current to cap or setting; back off to hold supply floor.
// - Status bit shows when the input voltage loop limits current.
// - Floor code decodes as 4.213 V plus 80 mV per step.
// - Battery above short threshold reloads safety default; host sets it first.
// - Any other register write locks safety until battery falls below short.
// - Float voltage or current written above ceiling stores the ceiling instead.
// - Current ceiling 550 mA plus 100 mA per step, 1550 mA from ten.
// - Voltage ceiling code 100011 plus one per step, capped from twelve.
// - Thermal foldback cuts output current to 550 mA.
// - Thermal shutdown suspends charging, loads fault 101, pulses event pin.
// - Thermal suspend halts timers, keeps state, resumes once die cools.
// - Supply under battery plus offset but above minimum enters sleep, blocks reverse.
// - Supply below minimum ends charging, pulses pin, status 11, fault 011.
// - After under-voltage, restart when supply recovers after the retry interval.
// - Over-voltage opens input switch, suspends, fault 001, status 11, pulses pin.
// - Over-voltage clears with hysteresis; charging resumes after revalidation.
// - Fault pulse on event pin is a 128 us low pulse.
// - Fault code is read in the low three bits of address zero.
module chg_limit_fault import chg_pkg::*; #(
	parameter int unsigned RETRY_CYCLES = RETRY_CYC,
	parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic batAboveShort,
	input wire logic dieFoldback,
	input wire logic dieShutdown,
	input wire logic dieCooled,
	input wire logic busBelowSleep,
	input wire logic busBelowMin,
	input wire logic busAboveMinRise,
	input wire logic busAboveOvp,
	input wire logic busOvpCleared,
	input wire logic busValidated,
	input wire logic busAtFloor,
	output logic chargeEnable,
	output logic inputSwitchOn,
	output logic reverseBlockOn,
	output logic timersHalt,
	output logic [11:0] inputCapMa,
	output logic [12:0] inputFloorMv,
	output logic [11:0] chargeDemandMa,
	output logic statPinOut,
	output logic statPinOeN
);
	initial begin
		if (RETRY_CYCLES < 1 || RETRY_CYCLES > 32'h1FFF_FFFF) $error("RETRY_CYCLES out of range");
	end

	function automatic logic [11:0] capDecode(input logic [1:0] code);
		case (code)
			2'h0: capDecode = CAP_MA_0;
			2'h1: capDecode = CAP_MA_1;
			2'h2: capDecode = CAP_MA_2;
			default: capDecode = CAP_NO_LIMIT;
		endcase
	endfunction

	function automatic logic [11:0] curDecode(input logic [3:0] code);
		if (code > ICEIL_LAST) curDecode = CUR_MAX_MA;
		else curDecode = 12'(CUR_BASE_MA + CUR_STEP_MA * 12'(code));
	endfunction

	function automatic logic [5:0] vceilDecode(input logic [3:0] code);
		if (code > VCEIL_LAST) vceilDecode = 6'(VCEIL_BASE_CODE + 6'(VCEIL_LAST) + 6'h01);
		else vceilDecode = 6'(VCEIL_BASE_CODE + 6'(code));
	endfunction

	// Comparator pins are asynchronous to clk_sys
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
	always_comb begin
		nxt_syncA = {busAtFloor, busValidated, busOvpCleared, busAboveOvp, busAboveMinRise, busBelowMin,
			busBelowSleep, dieCooled, dieShutdown, dieFoldback, batAboveShort};
		nxt_syncB = syncA_ff;
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncA_ff <= '0;
			syncB_ff <= '0;
		end else begin
			syncA_ff <= nxt_syncA;
			syncB_ff <= nxt_syncB;
		end
	end
	logic sBatShort, sFold, sShut, sCool, sSleep, sUvlo, sUvRise, sOvp, sOvpClr, sValid, sFloor;
	assign {sFloor, sValid, sOvpClr, sOvp, sUvRise, sUvlo, sSleep, sCool, sShut, sFold, sBatShort} = syncB_ff;

	// Register file
	logic [7:0] inLimit_ff, floatV_ff, chgCur_ff, floor_ff, safety_ff, safePend_ff;
	logic safeOpen_ff, safePendValid_ff, batShortPrev_ff;
	logic [7:0] nxt_inLimit, nxt_floatV, nxt_chgCur, nxt_floor, nxt_safety, nxt_safePend;
	logic nxt_safeOpen, nxt_safePendValid;
	logic [3:0] iceil, vceil;
	logic wrOther, wrSafety;
	assign iceil = safety_ff[ICEIL_LSB +: 4];
	assign vceil = safety_ff[VCEIL_LSB +: 4];
	assign wrSafety = regWrStb && (regAddr == ADDR_SAFETY);
	assign wrOther = regWrStb && (regAddr != ADDR_SAFETY);

	always_comb begin
		nxt_inLimit = inLimit_ff;
		nxt_floatV = floatV_ff;
		nxt_chgCur = chgCur_ff;
		nxt_floor = floor_ff;
		nxt_safety = safety_ff;
		nxt_safePend = safePend_ff;
		nxt_safeOpen = safeOpen_ff;
		nxt_safePendValid = safePendValid_ff;
		if (wrOther) begin
			case (regAddr)
				ADDR_INPUT_LIMIT: nxt_inLimit = regWrData;
				ADDR_FLOAT_VOLT: begin
					nxt_floatV = regWrData;
					if (regWrData[FLOAT_LSB +: 6] > vceilDecode(vceil)) nxt_floatV[FLOAT_LSB +: 6] = vceilDecode(vceil);
				end
				ADDR_CHARGE_CUR: begin
					nxt_chgCur = regWrData;
					if (regWrData[CUR_LSB +: 4] > iceil) nxt_chgCur[CUR_LSB +: 4] = iceil;
				end
				ADDR_FLOOR: nxt_floor = {regWrData[7:4], 1'b0, regWrData[2:0]};
				default: ;
			endcase
			nxt_safeOpen = 1'b0;
			nxt_safePendValid = 1'b0;
		end else if (wrSafety && safeOpen_ff) begin
			if (safePendValid_ff && (safePend_ff == regWrData)) begin
				nxt_safety = regWrData;
				nxt_safePendValid = 1'b0;
			end else begin
				nxt_safePend = regWrData;
				nxt_safePendValid = 1'b1;
			end
		end
		// reload default on battery rising above short
		if (sBatShort && !batShortPrev_ff) begin
			nxt_safety = SAFETY_RST;
			nxt_safeOpen = 1'b1;
			nxt_safePendValid = 1'b0;
		end else if (!sBatShort) begin
			// lock lasts until battery falls below short
			nxt_safeOpen = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			inLimit_ff <= INPUT_LIMIT_RST;
			floatV_ff <= FLOAT_VOLT_RST;
			chgCur_ff <= CHARGE_CUR_RST;
			floor_ff <= FLOOR_RST;
			safety_ff <= SAFETY_RST;
			safePend_ff <= 8'h00;
			safeOpen_ff <= 1'b1;
			safePendValid_ff <= 1'b0;
			batShortPrev_ff <= 1'b0;
		end else begin
			inLimit_ff <= nxt_inLimit;
			floatV_ff <= nxt_floatV;
			chgCur_ff <= nxt_chgCur;
			floor_ff <= nxt_floor;
			safety_ff <= nxt_safety;
			safePend_ff <= nxt_safePend;
			safeOpen_ff <= nxt_safeOpen;
			safePendValid_ff <= nxt_safePendValid;
			batShortPrev_ff <= sBatShort;
		end
	end

	// Charge control and fault reporting
	chg_state_e state_ff, nxt_state;
	logic [28:0] retry_ff, nxt_retry;
	logic [2:0] fault_ff, nxt_fault;
	logic [11:0] demand_ff, nxt_demand;
	logic [7:0] rdData_ff, nxt_rdData;
	logic faultEv;
	logic [2:0] faultCode;
	logic loopActive;
	logic [11:0] capMa, foldMa, targetMa;
	logic [1:0] statusCode;

	assign capMa = capDecode(inLimit_ff[CAP_LSB +: 2]);
	assign foldMa = (sFold && curDecode(chgCur_ff[CUR_LSB +: 4]) > FOLDBACK_MA) ? FOLDBACK_MA
		: curDecode(chgCur_ff[CUR_LSB +: 4]);
	assign targetMa = (capMa < foldMa) ? capMa : foldMa;
	assign loopActive = (state_ff == ST_CHARGE) && sFloor;

	always_comb begin
		nxt_state = state_ff;
		nxt_retry = retry_ff;
		faultEv = 1'b0;
		faultCode = FLT_NONE;
		case (state_ff)
			ST_IDLE: begin
				if (sOvp) begin
					nxt_state = ST_OVP;
					faultEv = 1'b1;
					faultCode = FLT_OVP;
				end else if (sValid && !sUvlo && !sSleep && !sShut) begin
					nxt_state = ST_CHARGE;
				end
			end
			ST_CHARGE: begin
				if (sOvp) begin
					nxt_state = ST_OVP;
					faultEv = 1'b1;
					faultCode = FLT_OVP;
				end else if (sShut) begin
					nxt_state = ST_THERM;
					faultEv = 1'b1;
					faultCode = FLT_THERM;
				end else if (sUvlo) begin
					nxt_state = ST_UVWAIT;
					nxt_retry = 29'(RETRY_CYCLES);
					faultEv = 1'b1;
					faultCode = FLT_UVLO;
				end else if (sSleep) begin
					nxt_state = ST_SLEEP;
				end
			end
			// resume at programmed current once cool
			ST_THERM: begin
				if (sOvp) begin
					nxt_state = ST_OVP;
					faultEv = 1'b1;
					faultCode = FLT_OVP;
				end else if (sCool && !sShut) begin
					nxt_state = ST_CHARGE;
				end
			end
			ST_UVWAIT: begin
				if (retry_ff != 29'h0) nxt_retry = retry_ff - 29'h1;
				if (sOvp) begin
					nxt_state = ST_OVP;
					faultEv = 1'b1;
					faultCode = FLT_OVP;
				end else if (retry_ff == 29'h0 && sUvRise) begin
					nxt_state = ST_IDLE;
				end
			end
			// clear with hysteresis, then revalidate in idle
			ST_OVP: begin
				if (sOvpClr && !sOvp) nxt_state = ST_IDLE;
			end
			ST_SLEEP: begin
				if (sOvp) begin
					nxt_state = ST_OVP;
					faultEv = 1'b1;
					faultCode = FLT_OVP;
				end else if (sUvlo || !sSleep) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_comb begin
		nxt_fault = fault_ff;
		// Reading the status clears the fault; a fault in the same cycle wins
		if (regRdStb && regAddr == ADDR_STATUS) nxt_fault = FLT_NONE;
		if (faultEv) nxt_fault = faultCode;
		// ramp up to target, back off at the floor
		nxt_demand = demand_ff;
		if (state_ff != ST_CHARGE && state_ff != ST_THERM) begin
			nxt_demand = 12'h000;
		end else if (state_ff == ST_CHARGE) begin
			if (demand_ff > targetMa) nxt_demand = targetMa;
			else if (sFloor && demand_ff != 12'h000) nxt_demand = demand_ff - 12'h001;
			else if (!sFloor && demand_ff < targetMa) nxt_demand = demand_ff + 12'h001;
		end
	end

	always_comb begin
		if (fault_ff != FLT_NONE && state_ff != ST_CHARGE) statusCode = STS_FAULT;
		else if (state_ff == ST_CHARGE || state_ff == ST_THERM) statusCode = STS_CHARGING;
		else statusCode = STS_READY;
		nxt_rdData = 8'h00;
		if (regRdStb) begin
			case (regAddr)
				ADDR_STATUS: begin
					nxt_rdData[STAT_LSB +: 2] = statusCode;
					nxt_rdData[FAULT_LSB +: 3] = fault_ff;
				end
				ADDR_INPUT_LIMIT: nxt_rdData = inLimit_ff;
				ADDR_FLOAT_VOLT: nxt_rdData = floatV_ff;
				ADDR_CHARGE_CUR: nxt_rdData = chgCur_ff;
				ADDR_FLOOR: nxt_rdData = {floor_ff[7:4], loopActive, floor_ff[2:0]};
				ADDR_SAFETY: nxt_rdData = safety_ff;
				default: nxt_rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			retry_ff <= 29'h0;
			fault_ff <= FLT_NONE;
			demand_ff <= 12'h000;
			rdData_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			retry_ff <= nxt_retry;
			fault_ff <= nxt_fault;
			demand_ff <= nxt_demand;
			rdData_ff <= nxt_rdData;
		end
	end

	logic pulsing;
	chg_stat_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.trigger(faultEv),
		.pulseActive(pulsing)
	);

	assign regRdData = rdData_ff;
	assign chargeEnable = (state_ff == ST_CHARGE);
	assign inputSwitchOn = (state_ff != ST_OVP);
	assign reverseBlockOn = (state_ff == ST_SLEEP);
	assign timersHalt = (state_ff == ST_THERM);
	assign inputCapMa = capMa;
	assign inputFloorMv = 13'(FLOOR_BASE_MV + FLOOR_STEP_MV * 13'(floor_ff[2:0]));
	assign chargeDemandMa = demand_ff;
	assign statPinOut = 1'b0;
	assign statPinOeN = !pulsing;

	a_ovp_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_ff != ST_OVP && sOvp) |=> (state_ff == ST_OVP && !inputSwitchOn && fault_ff == FLT_OVP
		&& !statPinOeN))
		else $error("over-voltage entry wrong");
	a_therm_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_ff == ST_CHARGE && !sOvp && sShut) |=> (fault_ff == FLT_THERM && timersHalt && !chargeEnable))
		else $error("thermal shutdown entry wrong");
	a_uv_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_ff == ST_CHARGE && !sOvp && !sShut && sUvlo) |=> (fault_ff == FLT_UVLO
		&& retry_ff == 29'(RETRY_CYCLES) && !chargeEnable))
		else $error("under-voltage entry wrong");
	a_uv_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_ff == ST_UVWAIT && retry_ff != 29'h0 && !sOvp) |=> (state_ff == ST_UVWAIT))
		else $error("retry left before interval");
	a_sleep_block: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_ff == ST_CHARGE && !sOvp && !sShut && !sUvlo && sSleep) |=> reverseBlockOn)
		else $error("sleep not entered");
	a_clamp_cur: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(chgCur_ff) && !$changed(safety_ff) |-> chgCur_ff[CUR_LSB +: 4] <= iceil)
		else $error("charge current above ceiling");
	a_safe_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wrSafety && !safeOpen_ff && !(sBatShort && !batShortPrev_ff)) |=> $stable(safety_ff))
		else $error("safety changed while locked");
	a_safe_twice: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(safety_ff) |-> (safety_ff == SAFETY_RST) || ($past(wrSafety) && $past(safePendValid_ff)
		&& $past(safePend_ff) == safety_ff))
		else $error("safety set without matching second write");
	a_fold_cap: assert property (@(posedge clk_sys) disable iff (!rstn)
		sFold && state_ff == ST_CHARGE ##1 sFold |-> demand_ff <= FOLDBACK_MA || $past(demand_ff) > FOLDBACK_MA)
		else $error("foldback current exceeded");
	a_floor_back: assert property (@(posedge clk_sys) disable iff (!rstn)
		(loopActive && demand_ff != 12'h000 && demand_ff <= targetMa && !sOvp && !sShut && !sUvlo && !sSleep)
		|=> demand_ff == $past(demand_ff) - 12'h001)
		else $error("floor loop did not back off");

	c_ovp_seen: cover property (@(posedge clk_sys) disable iff (!rstn) state_ff == ST_OVP);
	c_uv_retry: cover property (@(posedge clk_sys) disable iff (!rstn) state_ff == ST_UVWAIT ##1 state_ff == ST_IDLE);
	c_therm_resume: cover property (@(posedge clk_sys) disable iff (!rstn) state_ff == ST_THERM ##1 state_ff == ST_CHARGE);
	c_safe_set: cover property (@(posedge clk_sys) disable iff (!rstn) $changed(safety_ff) && safety_ff != SAFETY_RST);
endmodule // chg_limit_fault

/* File: chg_host_model.sv */
// Host processor model on the parallel register port
`timescale 1ns/1ps
module chg_host_model import chg_pkg::*; (
	input wire logic clk_sys,
	output logic regWrStb,
	output logic regRdStb,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	initial begin
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int beats);
		@(negedge clk_sys);
		regAddr = a;
		regWrData = d;
		regWrStb = 1'b1;
		repeat (beats) @(negedge clk_sys);
		regWrStb = 1'b0;
		// Released bus shows a changed pattern so stale data cannot pass
		regWrData = ~d;
		regAddr = ~a;
	endtask
	// same byte on two back-to-back writes
	task automatic safe(input logic [7:0] d);
		wr(ADDR_SAFETY, d, 2);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regRdStb = 1'b1;
		@(negedge clk_sys);
		regRdStb = 1'b0;
		d = regRdData;
		regAddr = ~a;
	endtask
endmodule // chg_host_model

/* File: test_charger_limit_and_fault_logic.sv */
// Self-checking bench for the charger limit and fault logic
`timescale 1ns/1ps
module test_charger_limit_and_fault_logic import chg_pkg::*;;
	localparam int PULSE = 8;
	logic clk_sys, rstn, batAboveShort, dieFoldback, dieShutdown, dieCooled, busBelowSleep, busBelowMin;
	logic busAboveMinRise, busAboveOvp, busOvpCleared, busValidated, busAtFloor;
	logic regWrStb, regRdStb, chargeEnable, inputSwitchOn, reverseBlockOn, timersHalt, statPinOut, statPinOeN;
	logic [7:0] regAddr, regWrData, regRdData, rdv, d;
	logic [11:0] inputCapMa, chargeDemandMa;
	logic [12:0] inputFloorMv;
	int n_mismatch, check_count, tgt;
	logic [7:0] rstAddr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
	chg_limit_fault #(.RETRY_CYCLES(50), .PULSE_CYCLES(PULSE)) chg_limit_fault_i (.clk_sys, .rstn, .regWrStb,
		.regRdStb, .regAddr, .regWrData, .regRdData, .batAboveShort, .dieFoldback, .dieShutdown, .dieCooled,
		.busBelowSleep, .busBelowMin, .busAboveMinRise, .busAboveOvp, .busOvpCleared, .busValidated, .busAtFloor,
		.chargeEnable, .inputSwitchOn, .reverseBlockOn, .timersHalt, .inputCapMa, .inputFloorMv, .chargeDemandMa,
		.statPinOut, .statPinOeN);
	chg_host_model chg_host_model_i (.clk_sys, .regWrStb, .regRdStb, .regAddr, .regWrData, .regRdData);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	function automatic logic [11:0] capMa(int c);
		return (c == 0) ? 12'd100 : (c == 1) ? 12'd500 : (c == 2) ? 12'd800 : 12'hFFF;
	endfunction
	function automatic int iceilMa(int c);
		return (c > 9) ? 1550 : 550 + 100 * c;
	endfunction
	function automatic logic [7:0] vceilSet(int c);
		return 8'(((c > 11) ? 'h2F : 'h23 + c) << 2);
	endfunction
	function automatic logic sig(int s);
		case (s)
			0: return chargeEnable;
			1: return reverseBlockOn;
			2: return statPinOeN;
			default: return chargeDemandMa === 12'(tgt);
		endcase
	endfunction
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		chg_host_model_i.rd(a, rdv);
		chk($sformatf("reg%h", a), 16'(rdv & m), 16'(exp));
	endtask
	task automatic waitUntil(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (sig(s) !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		if (sig(s) !== v) begin
			chk($sformatf("wait%0d", s), 16'h0, 16'h1);
			test_done();
		end
	endtask
	task automatic pulse;
		int n;
		n = 0;
		waitUntil(2, 1'b0, 10);
		while (statPinOeN === 1'b0 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		chk("pulseLen", 16'(n), 16'(PULSE));
		chk("pinLevel", 16'(statPinOut), 16'h0);
	endtask
	// Battery dips below short threshold and returns, reopening the ceiling
	task automatic unlock;
		batAboveShort = 1'b0;
		repeat (4) @(negedge clk_sys);
		batAboveShort = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask
	initial begin
		void'($urandom(32'hE9D1));
		rstn = 1'b0;
		{batAboveShort, dieFoldback, dieShutdown, busBelowSleep, busBelowMin} = '0;
		{busAboveOvp, busOvpCleared, busValidated, busAtFloor} = '0;
		busAboveMinRise = 1'b1;
		dieCooled = 1'b1;
		repeat (10) @(negedge clk_sys);
		rstn = 1'b1;
		foreach (rstAddr[i]) rchk(rstAddr[i], 8'hFF, 8'h00);
		unlock();
		chg_host_model_i.safe(8'h77);
		chg_host_model_i.wr(ADDR_SAFETY, 8'h78, 1);
		rchk(ADDR_SAFETY, 8'hFF, 8'h77);
		chg_host_model_i.safe(8'h35);
		rchk(ADDR_SAFETY, 8'hFF, 8'h35);
		chg_host_model_i.wr(ADDR_FLOAT_VOLT, 8'hFC, 1);
		rchk(ADDR_FLOAT_VOLT, 8'hFC, vceilSet(5));
		chg_host_model_i.wr(ADDR_CHARGE_CUR, 8'hF7, 1);
		rchk(ADDR_CHARGE_CUR, 8'hFF, 8'h37);
		chg_host_model_i.wr(ADDR_CHARGE_CUR, 8'h27, 1);
		rchk(ADDR_CHARGE_CUR, 8'hFF, 8'h27);
		chg_host_model_i.safe(8'h00);
		rchk(ADDR_SAFETY, 8'hFF, 8'h35);
		unlock();
		rchk(ADDR_SAFETY, 8'hFF, 8'h00);
		for (int i = 0; i < 16; i++) begin
			unlock();
			chg_host_model_i.safe({i[3:0], i[3:0]});
			chg_host_model_i.wr(ADDR_FLOAT_VOLT, 8'hFF, 1);
			rchk(ADDR_FLOAT_VOLT, 8'hFC, vceilSet(i));
			chg_host_model_i.wr(ADDR_CHARGE_CUR, 8'hF0, 1);
			rchk(ADDR_CHARGE_CUR, 8'hF0, {i[3:0], 4'h0});
		end
		unlock();
		chg_host_model_i.safe(8'hA0);
		chg_host_model_i.wr(ADDR_CHARGE_CUR, 8'hF0, 1);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			d[7:6] = i[1:0];
			chg_host_model_i.wr(ADDR_INPUT_LIMIT, d, 1);
			chk("cap", 16'(inputCapMa), 16'(capMa(i % 4)));
			rchk(ADDR_INPUT_LIMIT, 8'hFF, d);
			chg_host_model_i.wr(ADDR_FLOOR, {d[7:3], i[2:0]}, 1);
			chk("floor", 16'(inputFloorMv), 16'(4213 + 80 * i));
			rchk(ADDR_FLOOR, 8'hF7, {d[7:4], 1'b0, i[2:0]});
		end
		chg_host_model_i.wr(ADDR_INPUT_LIMIT, 8'hC0, 1);
		dieFoldback = 1'b1;
		busValidated = 1'b1;
		tgt = 550;
		waitUntil(3, 1'b1, 1000);
		repeat (20) @(negedge clk_sys);
		chk("foldback", 16'(chargeDemandMa), 16'(tgt));
		rchk(ADDR_STATUS, 8'h37, 8'h10);
		dieFoldback = 1'b0;
		tgt = iceilMa(10);
		waitUntil(3, 1'b1, 1200);
		repeat (20) @(negedge clk_sys);
		chk("demandCap", 16'(chargeDemandMa), 16'(tgt));
		busAtFloor = 1'b1;
		repeat (20) @(negedge clk_sys);
		chk("backOff", 16'(chargeDemandMa < 12'(tgt)), 16'h1);
		rchk(ADDR_FLOOR, 8'h08, 8'h08);
		busAtFloor = 1'b0;
		repeat (4) @(negedge clk_sys);
		rchk(ADDR_FLOOR, 8'h08, 8'h00);
		waitUntil(3, 1'b1, 200);
		dieShutdown = 1'b1;
		dieCooled = 1'b0;
		pulse();
		chk("thermEn", 16'(chargeEnable), 16'h0);
		chk("halt", 16'(timersHalt), 16'h1);
		repeat (10) @(negedge clk_sys);
		chk("held", 16'(chargeDemandMa), 16'(tgt));
		rchk(ADDR_STATUS, 8'h37, 8'h35);
		dieShutdown = 1'b0;
		dieCooled = 1'b1;
		waitUntil(0, 1'b1, 10);
		chk("resume", 16'(chargeDemandMa), 16'(tgt));
		dieShutdown = 1'b1;
		dieCooled = 1'b0;
		repeat (14) @(negedge clk_sys);
		busAboveOvp = 1'b1;
		pulse();
		chk("switch", 16'(inputSwitchOn), 16'h0);
		rchk(ADDR_STATUS, 8'h37, 8'h31);
		{dieShutdown, busValidated, busAboveOvp} = '0;
		dieCooled = 1'b1;
		busOvpCleared = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk("switchBack", 16'(inputSwitchOn), 16'h1);
		chk("noValid", 16'(chargeEnable), 16'h0);
		busValidated = 1'b1;
		waitUntil(0, 1'b1, 10);
		busOvpCleared = 1'b0;
		busBelowMin = 1'b1;
		busAboveMinRise = 1'b0;
		pulse();
		rchk(ADDR_STATUS, 8'h37, 8'h33);
		busBelowMin = 1'b0;
		busAboveMinRise = 1'b1;
		repeat (15) @(negedge clk_sys);
		chk("retryWait", 16'(chargeEnable), 16'h0);
		waitUntil(0, 1'b1, 100);
		busBelowSleep = 1'b1;
		waitUntil(1, 1'b1, 10);
		chk("sleepEn", 16'(chargeEnable), 16'h0);
		chk("sleepPin", 16'(statPinOeN), 16'h1);
		busBelowSleep = 1'b0;
		waitUntil(0, 1'b1, 10);
		rchk(ADDR_STATUS, 8'h37, 8'h10);
		test_done();
	end
endmodule // test_charger_limit_and_fault_logic
